// *** core/ues_pkg.sv ***
package ues_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0]  SEL_OFS       = 4'h0;
  localparam logic [3:0]  COUNT_OFS     = 4'h4;
  localparam logic [3:0]  STATUS_OFS    = 4'h8;
  localparam int          SEL_EVT_LSB   = 0;
  localparam int          SEL_MASK_LSB  = 8;
  localparam int          SEL_EN_BIT    = 16;
  localparam logic [16:0] SEL_RST       = 17'h00000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ------------------------------------------------------------
  // Event encodings, {event number, unit mask}
  // ------------------------------------------------------------
  localparam int NUM_CODES = 22;
  localparam logic [15:0] CODES [NUM_CODES] = '{
    16'h2f20, 16'h2f38,
    16'h3001, 16'h3002, 16'h3004, 16'h3007,
    16'h3101, 16'h3102, 16'h3104, 16'h3107,
    16'h3304,
    16'h4001, 16'h4002, 16'h4004,
    16'h4008, 16'h4010, 16'h4020,
    16'h4007, 16'h4038,
    16'h4101, 16'h4102, 16'h4104
  };
  localparam logic [15:0] PARTIAL_ALL_CODE = 16'h2f38;
  localparam logic [15:0] CANCEL_ALL_CODE  = 16'h3007;
  localparam logic [15:0] STALL_L0_CODE    = 16'h4007;
endpackage : ues_pkg

// *** core/ues_selector.sv ***
// Functional notes
// - Event 2F/20: partial writes, channel 2
// - Event 2F/38: partial writes, any channel
// - Event 30/01,02,04: cancels per channel
// - Event 30/07: cancels, all channels
// - Event 31/01,02,04: priority updates per channel
// - Update: isochronous request meets issued normal
// - Send update message to memory controller
// - Event 31/07: priority updates, all channels
// - Event 33/04: force-ack conflicts to local home
// - Event 40/01: link 0 home stall cycles
// - Event 40/02: link 0 snoop stall cycles
// - Event 40/04: link 0 non-data response stalls
// - Event 40/08,10,20: link 1 stall cycles
// - Event 40/07: link 0 single-flit stalls
// - Event 40/38: link 1 single-flit stalls
// - Stalls counted regardless of arbitration loss
// - Event 41/01: link 0 data response stalls
// - Event 41/02: link 0 bypass stalls
// - Event 41/04: link 0 standard stalls
module ues_selector #(
  parameter int CNT_W = 32
) (
  // Clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // AXI4-Lite slave
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Memory controller conditions, one bit per channel
  input  wire logic [2:0]           partial_write,
  input  wire logic [2:0]           dram_cancel,
  // Home logic conditions
  input  wire logic [2:0]           isochronous_class_req,
  input  wire logic [2:0]           normal_issued_match,
  input  wire logic                 force_ack_conflict,
  // Outbound link VCs: [0]=home [1]=snoop [2]=nondata resp
  input  wire logic [2:0]           l0_sf_pending,
  input  wire logic [2:0]           l1_sf_pending,
  // Link 0 multi-flit: [0]=data resp [1]=bypass [2]=standard
  input  wire logic [2:0]           l0_mf_pending,
  input  wire logic [1:0]           adaptive_vc_credit,
  input  wire logic [1:0]           dedicated_vc_credit,
  // Outputs
  output logic [2:0]                prio_update_msg,
  output logic                      count_inc
);

  // ------------------------------------------------------------
  // Condition vector
  // ------------------------------------------------------------
  logic [2:0] prio_evt;
  logic [2:0] l0_stall;
  logic [2:0] l1_stall;
  logic [2:0] l0_mf_stall;
  logic       credit_l0;
  logic       credit_l1;
  logic [ues_pkg::NUM_CODES-1:0] cond;

  // Issued normal request overtaken by an isochronous one
  assign prio_evt = isochronous_class_req & normal_issued_match;

  // No grant term here: a stall that would lose arbitration anyway
  // still counts, so counts can exceed true blocking time
  assign credit_l0   = adaptive_vc_credit[0] | dedicated_vc_credit[0];
  assign credit_l1   = adaptive_vc_credit[1] | dedicated_vc_credit[1];
  assign l0_stall    = l0_sf_pending & {3{~credit_l0}};
  assign l1_stall    = l1_sf_pending & {3{~credit_l1}};
  assign l0_mf_stall = l0_mf_pending & {3{~credit_l0}};

  // Order follows the code table in the package
  assign cond[0]     = partial_write[2];
  assign cond[1]     = |partial_write;
  assign cond[4:2]   = dram_cancel;
  assign cond[5]     = |dram_cancel;
  assign cond[8:6]   = prio_evt;
  assign cond[9]     = |prio_evt;
  assign cond[10]    = force_ack_conflict;
  assign cond[11]    = l0_stall[0];
  assign cond[12]    = l0_stall[1];
  assign cond[13]    = l0_stall[2];
  assign cond[16:14] = l1_stall;
  assign cond[17]    = |l0_stall;
  assign cond[18]    = |l1_stall;
  assign cond[19]    = l0_mf_stall[0];
  assign cond[20]    = l0_mf_stall[1];
  assign cond[21]    = l0_mf_stall[2];

  // ------------------------------------------------------------
  // Selection
  // ------------------------------------------------------------
  logic [16:0]                   sel_reg;
  logic [16:0]                   sel_next;
  logic [15:0]                   sel_code;
  logic                          sel_en;
  logic [ues_pkg::NUM_CODES-1:0] known;
  logic [ues_pkg::NUM_CODES-1:0] hit;
  logic                          sel_known;
  logic                          inc_now;

  assign sel_code = {sel_reg[ues_pkg::SEL_EVT_LSB +: 8],
                     sel_reg[ues_pkg::SEL_MASK_LSB +: 8]};
  assign sel_en   = sel_reg[ues_pkg::SEL_EN_BIT];

  // One comparator per listed encoding
  for (genvar i = 0; i < ues_pkg::NUM_CODES; i++) begin : g_match
    assign known[i] = (sel_code == ues_pkg::CODES[i]);
    assign hit[i]   = known[i] & cond[i];
  end

  // Unlisted pairs never count; at most one increment per cycle
  assign sel_known = |known;
  assign inc_now   = sel_en & (|hit);

  // Shared by both paths so that read and write agree on the map
  function automatic logic addr_mapped(input logic [3:0] a);
    return (a == ues_pkg::SEL_OFS) | (a == ues_pkg::COUNT_OFS) |
           (a == ues_pkg::STATUS_OFS);
  endfunction

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic        aw_got_reg;
  logic [3:0]  aw_addr_reg;
  logic        w_got_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_hs;
  logic        w_hs;
  logic        do_write;
  logic        wr_sel;
  logic        wr_cnt;
  logic        wr_ok;
  logic        cnt_clr;

  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  assign wr_sel   = do_write & (aw_addr_reg == ues_pkg::SEL_OFS);
  assign wr_cnt   = do_write & (aw_addr_reg == ues_pkg::COUNT_OFS);
  assign wr_ok    = addr_mapped(aw_addr_reg);
  assign cnt_clr  = wr_cnt & w_strb_reg[0];

  // Byte-enabled update of the select register
  assign sel_next = {
    (wr_sel & w_strb_reg[2]) ? w_data_reg[16] : sel_reg[16],
    (wr_sel & w_strb_reg[1]) ? w_data_reg[15:8] : sel_reg[15:8],
    (wr_sel & w_strb_reg[0]) ? w_data_reg[7:0] : sel_reg[7:0]};

  // Address and data are held until both are in
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_got_reg   <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else if (clk_en) begin
      if (aw_hs) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
      end else if (do_write) begin
        aw_got_reg <= 1'b0;
      end
      if (w_hs) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  // Ready drops once a beat is held, giving back-pressure
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_got_reg & ~aw_hs & ~s_axi_bvalid;
      s_axi_wready  <= ~w_got_reg & ~w_hs & ~s_axi_bvalid;
    end
  end

  // Write response
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ues_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? ues_pkg::RESP_OKAY
                              : ues_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Counter and select state
  // ------------------------------------------------------------
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // A clear racing an increment leaves one count behind
  assign count_next = cnt_clr ? {{(CNT_W-1){1'b0}}, inc_now}
                              : count_reg + {{(CNT_W-1){1'b0}}, inc_now};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sel_reg   <= ues_pkg::SEL_RST;
      count_reg <= '0;
      count_inc <= 1'b0;
    end else if (clk_en) begin
      sel_reg   <= sel_next;
      count_reg <= count_next;
      count_inc <= inc_now;
    end
  end

  // Update message toward the memory controller
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prio_update_msg <= 3'h0;
    end else if (clk_en) begin
      prio_update_msg <= prio_evt;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  logic        ar_hs;
  logic [3:0]  rd_addr;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign ar_hs   = s_axi_arvalid & s_axi_arready;
  assign rd_addr = {s_axi_araddr[3:2], 2'h0};
  assign rd_ok   = addr_mapped(rd_addr);
  // Status: bit0 selection is listed, bit1 counted in the previous cycle
  assign rd_word =
    (rd_addr == ues_pkg::SEL_OFS)   ? {15'h0000, sel_reg} :
    (rd_addr == ues_pkg::COUNT_OFS) ? 32'(count_reg) :
    (rd_addr == ues_pkg::STATUS_OFS) ?
      {30'h00000000, count_inc, sel_known} : 32'h00000000;

  // One read in flight; a wide counter is cut to 32 bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ues_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? ues_pkg::RESP_OKAY
                              : ues_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  prio_msg_a: assert property (clk_en |=>
    prio_update_msg == $past(isochronous_class_req & normal_issued_match))
    else $error("priority update message wrong");
  prio_cnt_a: assert property (clk_en && sel_en &&
    sel_code == 16'h3102 |=> count_inc ==
    $past(isochronous_class_req[1] & normal_issued_match[1]))
    else $error("channel 1 priority count wrong");
  prio_sum_a: assert property (clk_en && sel_en &&
    sel_code == 16'h3107 |=> count_inc ==
    $past(|(isochronous_class_req & normal_issued_match)))
    else $error("priority update aggregate wrong");
  part_any_a: assert property (clk_en && sel_en &&
    sel_code == ues_pkg::PARTIAL_ALL_CODE && |partial_write
    |=> count_inc)
    else $error("partial write missed");
  part_ch2_a: assert property (clk_en && sel_en &&
    sel_code == 16'h2f20 |=> count_inc == $past(partial_write[2]))
    else $error("channel 2 partial write wrong");
  cancel_ch0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h3001 |=> count_inc == $past(dram_cancel[0]))
    else $error("channel 0 cancel count wrong");
  cancel_all_a: assert property (clk_en && sel_en &&
    sel_code == ues_pkg::CANCEL_ALL_CODE |=>
    count_inc == $past(|dram_cancel))
    else $error("cancel aggregate wrong");
  force_ack_a: assert property (clk_en && sel_en &&
    sel_code == 16'h3304 |=> count_inc == $past(force_ack_conflict))
    else $error("force-ack conflict count wrong");
  home_l0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4001 |=> count_inc == $past(l0_sf_pending[0] &
    ~adaptive_vc_credit[0] & ~dedicated_vc_credit[0]))
    else $error("link 0 home stall count wrong");
  snoop_l0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4002 |=> count_inc == $past(l0_sf_pending[1] &
    ~adaptive_vc_credit[0] & ~dedicated_vc_credit[0]))
    else $error("link 0 snoop stall count wrong");
  nondata_l0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4004 |=> count_inc == $past(l0_sf_pending[2] &
    ~adaptive_vc_credit[0] & ~dedicated_vc_credit[0]))
    else $error("link 0 non-data stall count wrong");
  stall_l0_a: assert property (clk_en && sel_en &&
    sel_code == ues_pkg::STALL_L0_CODE && |l0_sf_pending &&
    !adaptive_vc_credit[0] && !dedicated_vc_credit[0]
    |=> count_inc)
    else $error("link 0 stall missed");
  stall_l1_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4038 |=> count_inc == $past((|l1_sf_pending) &
    ~adaptive_vc_credit[1] & ~dedicated_vc_credit[1]))
    else $error("link 1 stall aggregate wrong");
  credit_ok_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4010 && credit_l1 |=> !count_inc)
    else $error("stall counted with credit");
  drs_l0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4101 |=> count_inc == $past(l0_mf_pending[0] &
    ~adaptive_vc_credit[0] & ~dedicated_vc_credit[0]))
    else $error("link 0 data response stall wrong");
  bypass_l0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4102 |=> count_inc == $past(l0_mf_pending[1] &
    ~adaptive_vc_credit[0] & ~dedicated_vc_credit[0]))
    else $error("link 0 bypass stall wrong");
  ncs_l0_a: assert property (clk_en && sel_en &&
    sel_code == 16'h4104 |=> count_inc == $past(l0_mf_pending[2] &
    ~adaptive_vc_credit[0] & ~dedicated_vc_credit[0]))
    else $error("link 0 standard stall wrong");
  no_match_a: assert property (clk_en && !sel_known
    |=> !count_inc)
    else $error("unlisted selection counted");
  disabled_a: assert property (clk_en && !sel_en
    |=> !count_inc)
    else $error("disabled selection counted");
  count_step_a: assert property (clk_en && inc_now && !cnt_clr
    |=> count_reg == $past(count_reg) + 1'b1)
    else $error("counter did not step by one");
  freeze_cnt_a: assert property (!clk_en
    |=> $stable(count_reg) && $stable(count_inc))
    else $error("counter moved while frozen");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  ua_write_c: cover property (aw_hs ##[1:4] s_axi_bvalid);
  ua_read_c:  cover property (ar_hs ##1 s_axi_rvalid);
  ua_prio_c:  cover property (|prio_evt && sel_en ##1 count_inc);
  ua_stall_c: cover property (|l1_stall [*3] ##1 count_inc);

endmodule // ues_selector

// *** tb/ues_far_model.sv ***
// ----
// Far side: memory controller, home logic, link logic
// ----
module ues_far_model (
  // Scenario word from the bench
  input  wire logic [25:0] scen,
  // Memory controller and home logic conditions
  output logic      [2:0]  partial_write,
  output logic      [2:0]  dram_cancel,
  output logic      [2:0]  isochronous_class_req,
  output logic      [2:0]  normal_issued_match,
  output logic             force_ack_conflict,
  // Outbound link virtual channels and credits
  output logic      [2:0]  l0_sf_pending,
  output logic      [2:0]  l1_sf_pending,
  output logic      [2:0]  l0_mf_pending,
  output logic      [1:0]  adaptive_vc_credit,
  output logic      [1:0]  dedicated_vc_credit
);
  timeunit 1ns;
  timeprecision 1ns;
  // Occurrences are one-cycle pulses, stalls are levels per cycle
  assign partial_write         = scen[2:0];
  assign dram_cancel           = scen[5:3];
  assign isochronous_class_req = scen[8:6];
  assign normal_issued_match   = scen[11:9];
  assign force_ack_conflict    = scen[12];
  // Pending and credits change freely, even while granted elsewhere
  assign l0_sf_pending         = scen[15:13];
  assign l1_sf_pending         = scen[18:16];
  assign l0_mf_pending         = scen[21:19];
  assign adaptive_vc_credit    = scen[23:22];
  assign dedicated_vc_credit   = scen[25:24];
endmodule // ues_far_model

// *** tb/ues_selector_tb.sv ***
module ues_selector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Signals
  // ----
  logic        sys_clk, resetn, clk_en;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, fa, inc;
  logic [2:0]  pw, dc, iso, nim, l0s, l1s, l0m, prio;
  logic [1:0]  avc, dvc;
  logic [25:0] scen;
  logic [3:0]  notes [$];
  int          mismatches, checked, seed;
  int unsigned total;
  // Selections: {enable, event, mask}; last four must never count
  // The register holds the mask above the event, so writes swap them
  logic [16:0] plan [26] = '{17'h12f20, 17'h12f38,
    17'h13001, 17'h13002, 17'h13004, 17'h13007,
    17'h13101, 17'h13102, 17'h13104, 17'h13107,
    17'h13304, 17'h14001, 17'h14002, 17'h14004,
    17'h14008, 17'h14010, 17'h14020, 17'h14007,
    17'h14038, 17'h14101, 17'h14102, 17'h14104,
    17'h13008, 17'h14108, 17'h12f07, 17'h03007};
  // ----
  // Design and far side
  // ----
  ues_selector uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .partial_write(pw), .dram_cancel(dc),
    .isochronous_class_req(iso), .normal_issued_match(nim),
    .force_ack_conflict(fa), .l0_sf_pending(l0s), .l1_sf_pending(l1s),
    .l0_mf_pending(l0m), .adaptive_vc_credit(avc),
    .dedicated_vc_credit(dvc), .prio_update_msg(prio), .count_inc(inc));
  ues_far_model far (.scen(scen), .partial_write(pw), .dram_cancel(dc),
    .isochronous_class_req(iso), .normal_issued_match(nim),
    .force_ack_conflict(fa), .l0_sf_pending(l0s), .l1_sf_pending(l1s),
    .l0_mf_pending(l0m), .adaptive_vc_credit(avc),
    .dedicated_vc_credit(dvc));
  // ----
  // Expected behaviour, worked out independently of the design
  // ----
  function automatic logic listed(input logic [15:0] c);
    return c inside {16'h2f20, 16'h2f38, 16'h3001, 16'h3002, 16'h3004,
      16'h3007, 16'h3101, 16'h3102, 16'h3104, 16'h3107, 16'h3304,
      16'h4001, 16'h4002, 16'h4004, 16'h4008, 16'h4010, 16'h4020,
      16'h4007, 16'h4038, 16'h4101, 16'h4102, 16'h4104};
  endfunction
  // Aggregates OR their lanes, so one increment per cycle at most
  function automatic logic hit(input logic [15:0] c, input logic [25:0] v);
    logic       s0, s1;
    logic [5:0] m;
    s0 = ~v[22] & ~v[24]; // No credit of either kind on link 0
    s1 = ~v[23] & ~v[25];
    m = c[5:0];
    case (c[15:8])
      8'h2f: return |(v[2:0] & m[5:3]);
      8'h30: return |(v[5:3] & m[2:0]);
      8'h31: return |(v[8:6] & v[11:9] & m[2:0]);
      8'h33: return v[12];
      8'h40: return |({v[18:16] & {3{s1}}, v[15:13] & {3{s0}}} & m);
      8'h41: return |(v[21:19] & {3{s0}} & m[2:0]);
      default: return 1'b0;
    endcase
  endfunction
  // ----
  // Checking and ending
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Output watcher takes the oldest note each cycle it has one
  always @(negedge sys_clk) begin
    if (notes.size() > 0)
      check({28'h0, prio, inc}, {28'h0, notes.pop_front()});
  end
  // ----
  // Bus master tasks; each request held until its ready edge
  // ----
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Random far-side traffic; the note lands one edge after sampling
  task automatic burst(input logic [16:0] p);
    logic [31:0] v;
    logic [3:0]  pend;
    total = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      if (k > 0) notes.push_back(pend);
      v = $random(seed);
      scen <= v[25:0];
      pend = {v[8:6] & v[11:9], p[16] & listed(p[15:0]) & hit(p[15:0], v[25:0])};
      total += pend[0];
    end
    @(posedge sys_clk);
    notes.push_back(pend);
    scen <= '0;
    @(posedge sys_clk);
  endtask
  // ----
  // Clock, watchdog, main sequence
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
  initial begin
    seed = 32'hebf1;
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    clk_en = 1'b1;
    scen = '0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    axi_rd(ues_pkg::SEL_OFS);
    check(d, {15'h0, ues_pkg::SEL_RST});
    axi_rd(4'hc);
    check({30'h0, r}, {30'h0, ues_pkg::RESP_SLVERR});
    axi_wr(4'hc, 32'h0);
    check({30'h0, r}, {30'h0, ues_pkg::RESP_SLVERR});
    $display("test unmapped done");
    for (int i = 0; i < 26; i++) begin
      axi_wr(ues_pkg::SEL_OFS,
        {15'h0, plan[i][16], plan[i][7:0], plan[i][15:8]});
      axi_rd(ues_pkg::STATUS_OFS);
      check({31'h0, d[0]}, {31'h0, listed(plan[i][15:0])});
      axi_wr(ues_pkg::COUNT_OFS, 32'h0);
      burst(plan[i]);
      axi_rd(ues_pkg::COUNT_OFS);
      check(d, total);
      $display("test select %h done, count %0d", plan[i], total);
    end
    // Frozen cycles must not count; the one enabled cycle counts once
    axi_wr(ues_pkg::SEL_OFS, 32'h0001382f);
    axi_wr(ues_pkg::COUNT_OFS, 32'h0);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    scen <= 26'h0000007;
    repeat (4) @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    scen <= '0;
    axi_rd(ues_pkg::COUNT_OFS);
    check(d, 32'h00000001);
    $display("test clock enable done");
    conclude();
  end
endmodule // ues_selector_tb
